// ===== design/loop_watchdog_cfg.svh
// register offsets, field positions, reset values and counting constants of the loop watchdog
// assumes a 16-bit cpu data address space with byte-wide registers
`ifndef LOOP_WATCHDOG_CFG_SVH
`define LOOP_WATCHDOG_CFG_SVH

`define WDG_MODE_ADDR        16'hFF48
`define WDG_RESTART_ADDR     16'hFF49
`define WDG_MODE_RESET       8'h67
`define WDG_RESTART_READ     8'h9A
`define WDG_RESTART_KEY      8'hAC
`define WDG_MODE_FIXED_TOP   3'h3
`define WDG_STOP_BIT         4
`define WDG_SOURCE_BIT       3
`define WDG_PERIOD_MSB       2
`define WDG_PERIOD_LSB       0
`define WDG_CAUSE_BIT        4
`define WDG_SLOW_BASE_EXP    11
`define WDG_SYS_BASE_EXP     13
`define WDG_CNT_WIDTH        21

`endif

// ===== design/loop_watchdog_pkg.sv
// types shared by the loop watchdog files
// assumes loop_watchdog_cfg.svh is compiled alongside
package loop_watchdog_pkg;

   typedef enum logic [1:0] {
      MODE_OPEN,
      MODE_RUN,
      MODE_STOPPED
   } mode_state_t;

   typedef enum logic {
      SRC_SLOW,
      SRC_SYS
   } clk_source_t;

endpackage : loop_watchdog_pkg

// ===== design/program_loop_watchdog.sv
// program loop watchdog: write-once mode register, restart key register, overflow counter
// assumes a byte cpu bus with a sideband flag for single-bit manipulation accesses,
// and that the raised reset request returns as rst
`timescale 1ns/1ns
`include "loop_watchdog_cfg.svh"

// Overview of operation
// - overflow without restart raises system reset request
// - watchdog reset sets cause flag bit four
// - bit4 stops; else bit3 picks slow/system clock
// - period n gives 2^(11+n) or 2^(13+n)
// - mode register resets to 67 hex
// - second mode write triggers reset, no change
// - stopped-first-write exempts later illegal accesses
// - unstoppable option forces slow clock, ignores select
// - restart key AC clears counter, resumes
// - restart write other than AC triggers reset
// - bit access to restart register triggers reset
// - restart register always reads 9A hex
// - any byte write to the mode register clears the counter
// - counting starts after reset, slow clock, longest
module program_loop_watchdog #(
   parameter int CNT_W = `WDG_CNT_WIDTH
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        por_rst,
   input  wire logic        slow_osc_clock,
   input  wire logic        osc_unstoppable,
   input  wire logic [15:0] bus_addr,
   input  wire logic [7:0]  bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   input  wire logic        bus_bit_access,
   input  wire logic        cause_clear,
   output logic [7:0]       bus_rdata,
   output logic             reset_request,
   output logic             watchdog_reset_cause_flag
);
   generate
      if (CNT_W < `WDG_CNT_WIDTH) begin : g_width_check
         $error("counter too narrow for the longest overflow period");
      end
   endgenerate

   // overflow compare value for a source and period code
   function automatic logic [CNT_W-1:0] period_last(input loop_watchdog_pkg::clk_source_t src,
                                                    input logic [2:0] n);
      logic [CNT_W-1:0] one;
      one = {{(CNT_W-1){1'b0}}, 1'b1};
      if (src == loop_watchdog_pkg::SRC_SYS)
         period_last = (one << (`WDG_SYS_BASE_EXP + n)) - one;
      else
         period_last = (one << (`WDG_SLOW_BASE_EXP + n)) - one;
   endfunction : period_last

   logic                          option_lock;
   logic [4:0]                    mode_low;
   loop_watchdog_pkg::mode_state_t mode_state;
   logic [CNT_W-1:0]              count;
   logic                          slow_tick;

   slow_tick_sync u_slow_sync (
      .clk_sys        (clk_sys),
      .rst            (rst),
      .slow_osc_clock (slow_osc_clock),
      .slow_tick      (slow_tick)
   );

   // register hit decode, shared by the write and the read path
   function automatic logic reg_hit(input logic [15:0] addr,
                                    input logic [15:0] target);
      reg_hit = (addr == target);
   endfunction : reg_hit

   // address decode
   wire hit_mode    = reg_hit(bus_addr, `WDG_MODE_ADDR);
   wire hit_restart = reg_hit(bus_addr, `WDG_RESTART_ADDR);
   wire byte_wr     = bus_wr & ~bus_bit_access;
   wire mode_wr     = hit_mode & byte_wr;
   wire restart_wr  = hit_restart & byte_wr;
   wire restart_bit = hit_restart & bus_bit_access & (bus_wr | bus_rd);
   wire key_ok      = restart_wr & (bus_wdata == `WDG_RESTART_KEY);
   wire key_bad     = restart_wr & (bus_wdata != `WDG_RESTART_KEY);
   wire exempt      = (mode_state == loop_watchdog_pkg::MODE_STOPPED);
   wire second_wr   = mode_wr & (mode_state != loop_watchdog_pkg::MODE_OPEN);
   wire illegal     = ~exempt & (second_wr | key_bad | restart_bit);

   // clock selection; the option strap overrides whatever was stored
   wire stopped = mode_low[`WDG_STOP_BIT] & ~option_lock;
   wire loop_watchdog_pkg::clk_source_t src =
      (mode_low[`WDG_SOURCE_BIT] & ~option_lock) ? loop_watchdog_pkg::SRC_SYS
                                                 : loop_watchdog_pkg::SRC_SLOW;
   wire tick      = ~stopped & ((src == loop_watchdog_pkg::SRC_SYS) | slow_tick);

   // one compare value per period code and source; the stored code only selects
   logic [CNT_W-1:0] last_slow [8];
   logic [CNT_W-1:0] last_sys  [8];
   for (genvar p = 0; p < 8; p++) begin : g_period
      assign last_slow[p] = period_last(loop_watchdog_pkg::SRC_SLOW, 3'(p));
      assign last_sys[p]  = period_last(loop_watchdog_pkg::SRC_SYS, 3'(p));
   end
   wire [2:0]       period_code = mode_low[`WDG_PERIOD_MSB:`WDG_PERIOD_LSB];
   wire [CNT_W-1:0] last        = (src == loop_watchdog_pkg::SRC_SYS) ? last_sys[period_code]
                                                                      : last_slow[period_code];
   wire overflow  = tick & (count == last);
   wire fire      = overflow | illegal;

   wire [4:0] wr_low = option_lock ? {2'b00, bus_wdata[`WDG_PERIOD_MSB:`WDG_PERIOD_LSB]}
                                   : bus_wdata[4:0];
   wire first_wr  = mode_wr & (mode_state == loop_watchdog_pkg::MODE_OPEN);
   wire first_stops = wr_low[`WDG_STOP_BIT];

   wire             count_clear     = mode_wr | key_ok;
   wire [CNT_W-1:0] count_inc       = count + {{(CNT_W-1){1'b0}}, 1'b1};
   wire [CNT_W-1:0] next_count      = count_clear ? '0 : (tick ? count_inc : count);
   wire [7:0]       mode_reset_full = `WDG_MODE_RESET;
   wire [4:0]       mode_reset_low  = mode_reset_full[4:0];

   // lifecycle: open until the first byte write, then locked running or stopped
   loop_watchdog_pkg::mode_state_t next_mode_state;
   always_comb begin
      next_mode_state = mode_state;
      case (mode_state)
         loop_watchdog_pkg::MODE_OPEN: begin
            if (first_wr)
               next_mode_state = first_stops ? loop_watchdog_pkg::MODE_STOPPED
                                             : loop_watchdog_pkg::MODE_RUN;
         end
         loop_watchdog_pkg::MODE_RUN:     next_mode_state = loop_watchdog_pkg::MODE_RUN;
         loop_watchdog_pkg::MODE_STOPPED: next_mode_state = loop_watchdog_pkg::MODE_STOPPED;
         // an unused code falls back to locked running, never reopening the register
         default:                         next_mode_state = loop_watchdog_pkg::MODE_RUN;
      endcase
   end

   // strap is sampled only while reset is held, so it cannot move under a running count
   always_ff @(posedge clk_sys) begin
      if (rst)
         option_lock <= osc_unstoppable;
   end

   always_ff @(posedge clk_sys) begin
      if (rst)
         mode_low <= mode_reset_low;
      else if (first_wr)
         mode_low <= wr_low;
   end

   always_ff @(posedge clk_sys) begin
      if (rst)
         mode_state <= loop_watchdog_pkg::MODE_OPEN;
      else
         mode_state <= next_mode_state;
   end

   always_ff @(posedge clk_sys) begin
      if (rst)
         count <= '0;
      else
         count <= next_count;
   end

   // request is held until the system reset comes back round
   always_ff @(posedge clk_sys) begin
      if (rst)
         reset_request <= 1'b0;
      else if (fire)
         reset_request <= 1'b1;
   end

   // cause flag survives the reset it causes; setting wins over a same-cycle clear
   always_ff @(posedge clk_sys) begin
      if (por_rst)
         watchdog_reset_cause_flag <= 1'b0;
      else if (fire)
         watchdog_reset_cause_flag <= 1'b1;
      else if (cause_clear)
         watchdog_reset_cause_flag <= 1'b0;
   end

   // read data; bits seven to five of the mode register are fixed
   wire [7:0] read_mux = hit_mode    ? {`WDG_MODE_FIXED_TOP, mode_low} :
                         hit_restart ? `WDG_RESTART_READ :
                                       8'h00;
   always_ff @(posedge clk_sys) begin
      if (rst)
         bus_rdata <= 8'h00;
      else if (bus_rd)
         bus_rdata <= read_mux;
   end
endmodule : program_loop_watchdog

// ===== design/slow_tick_sync.sv
// synchroniser and rising-edge detector for the low-speed oscillator clock pin
// assumes the oscillator runs far slower than clk_sys
`timescale 1ns/1ns
module slow_tick_sync (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic slow_osc_clock,
   output logic      slow_tick
);
   logic sync_a;
   logic sync_b;
   logic sync_c;
   logic level;
   wire  agree      = (sync_b == sync_c);
   wire  next_level = agree ? sync_c : level;

   // level only moves when the second and third stages agree, so one glitch cannot tick
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync_a    <= 1'b0;
         sync_b    <= 1'b0;
         sync_c    <= 1'b0;
         level     <= 1'b0;
         slow_tick <= 1'b0;
      end else begin
         sync_a    <= slow_osc_clock;
         sync_b    <= sync_a;
         sync_c    <= sync_b;
         level     <= next_level;
         slow_tick <= next_level & ~level;
      end
   end
endmodule : slow_tick_sync

// ===== test/cpu_model.sv
// cpu side model issuing byte and bit accesses to the watchdog registers
// assumes calls come from one process only
`timescale 1ns/1ns
module cpu_model (
   input  wire logic   clk_sys,
   output logic [15:0] bus_addr,
   output logic [7:0]  bus_wdata,
   output logic        bus_wr,
   output logic        bus_rd,
   output logic        bus_bit_access
);
   initial {bus_addr, bus_wdata, bus_wr, bus_rd, bus_bit_access} = '0;
   // two cycles per access, so a strobe is never lowered and raised in one step
   task automatic acc(input logic r, b, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys) #1;
      {bus_addr, bus_wdata, bus_rd, bus_wr, bus_bit_access} = {a, d, r, !r, b};
      @(posedge clk_sys) #1;
      {bus_addr, bus_wdata, bus_rd, bus_wr, bus_bit_access} = {~a, ~d, 3'h0};
   endtask : acc
endmodule : cpu_model

// ===== test/loop_watchdog_props.sv
// assertions on the loop watchdog top ports
// assumes a bind onto program_loop_watchdog, rst synchronous active high
`timescale 1ns/1ns
module loop_watchdog_props #(
   parameter int CNT_W = 21
) (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        por_rst,
   input wire logic        slow_osc_clock,
   input wire logic        osc_unstoppable,
   input wire logic [15:0] bus_addr,
   input wire logic [7:0]  bus_wdata,
   input wire logic        bus_wr,
   input wire logic        bus_rd,
   input wire logic        bus_bit_access,
   input wire logic        cause_clear,
   input wire logic [7:0]  bus_rdata,
   input wire logic        reset_request,
   input wire logic        watchdog_reset_cause_flag
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire  mode_wr = bus_wr && bus_addr == 16'hFF48 && !bus_bit_access;
   wire  rs_hit  = (bus_wr || bus_rd) && bus_addr == 16'hFF49;
   logic wrote;
   logic stop;
   // exemption holds only after a first write that really stopped counting
   always_ff @(posedge clk_sys) begin
      wrote <= !rst && (wrote || mode_wr);
      stop  <= !rst && (wrote ? stop : mode_wr && bus_wdata[4] && !osc_unstoppable);
   end
   AST_RST_CLR: assert property (disable iff (1'b0) rst |=> !reset_request)
      else $error("request not cleared");
   AST_REQ_HOLD: assert property (reset_request |=> reset_request)
      else $error("request dropped");
   AST_FLAG: assert property ($rose(reset_request) && !por_rst |-> watchdog_reset_cause_flag)
      else $error("cause flag not set");
   AST_BAD_KEY: assert property (!stop && rs_hit && bus_wr && bus_wdata != 8'hAC |=> reset_request)
      else $error("bad key ignored");
   AST_BIT_RS: assert property (!stop && rs_hit && bus_bit_access |=> reset_request)
      else $error("bit access ignored");
   AST_SECOND: assert property (!stop && wrote && mode_wr |=> reset_request)
      else $error("second mode write ignored");
   AST_EXEMPT: assert property (stop && !reset_request |=> !reset_request)
      else $error("reset while stopped");
   AST_RS_READ: assert property (rs_hit && bus_rd && !bus_bit_access |=> bus_rdata == 8'h9A)
      else $error("restart read wrong");
endmodule : loop_watchdog_props

// ===== test/program_loop_watchdog_bench.sv
// self-checking bench for program_loop_watchdog through cpu_model accesses
// assumes read data lands on the edge that samples the strobe
`timescale 1ns/1ns
module program_loop_watchdog_bench;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic por_rst = 1'b1;
   logic slow_osc_clock = 1'b0;
   logic osc_unstoppable = 1'b0;
   logic cause_clear = 1'b0;
   wire [15:0] bus_addr;
   wire [7:0]  bus_wdata, bus_rdata;
   wire        bus_wr, bus_rd, bus_bit_access, reset_request, watchdog_reset_cause_flag;
   int         fails = 0, tests_run = 0, cyc = 0;
   always #5 clk_sys = ~clk_sys;
   always #80 slow_osc_clock = ~slow_osc_clock;
   program_loop_watchdog DUT (.*);
   cpu_model cpu (.*);
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails = fails + 1;
         complete_run();
      end
   end
   task chk(input logic [7:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task rd(input logic [15:0] a, input logic [7:0] e);
      cpu.acc(1'b1, 1'b0, a, 8'h00);
      chk(bus_rdata, e);
   endtask : rd
   task req(input logic e);
      chk({7'h00, reset_request}, {7'h00, e});
   endtask : req
   task wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wt
   task restart(input logic u);
      wt(1);
      rst = 1'b1;
      osc_unstoppable = u;
      wt(4);
      rst = 1'b0;
   endtask : restart
   task complete_run;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      restart(1'b0);
      por_rst = 1'b0;
      rd(16'hFF48, 8'h67);
      rd(16'hFF49, 8'h9A);
      rd(16'hFF00, 8'h00);
      cpu.acc(1'b0, 1'b0, 16'hFF48, 8'h68);
      rd(16'hFF48, 8'h68);
      wt(5000);
      cpu.acc(1'b0, 1'b0, 16'hFF49, 8'hAC);
      wt(8150);
      req(1'b0);
      wt(50);
      req(1'b1);
      restart(1'b0);
      chk({7'h00, watchdog_reset_cause_flag}, 8'h01);
      cause_clear = 1'b1;
      wt(1);
      cause_clear = 1'b0;
      chk({7'h00, watchdog_reset_cause_flag}, 8'h00);
      cpu.acc(1'b0, 1'b1, 16'hFF49, 8'hAC);
      req(1'b1);
      restart(1'b0);
      cpu.acc(1'b0, 1'b0, 16'hFF49, 8'h00);
      req(1'b1);
      restart(1'b0);
      cpu.acc(1'b0, 1'b0, 16'hFF48, 8'h70);
      cpu.acc(1'b0, 1'b0, 16'hFF48, 8'h60);
      cpu.acc(1'b0, 1'b0, 16'hFF49, 8'h00);
      cpu.acc(1'b1, 1'b1, 16'hFF49, 8'h00);
      req(1'b0);
      restart(1'b0);
      cpu.acc(1'b0, 1'b1, 16'hFF48, 8'h60);
      cpu.acc(1'b0, 1'b0, 16'hFF48, 8'h61);
      cpu.acc(1'b0, 1'b0, 16'hFF48, 8'h62);
      req(1'b1);
      rd(16'hFF48, 8'h61);
      restart(1'b0);
      wt(3000);
      cpu.acc(1'b0, 1'b0, 16'hFF48, 8'h68);
      wt(8150);
      req(1'b0);
      wt(50);
      req(1'b1);
      restart(1'b1);
      cpu.acc(1'b0, 1'b0, 16'hFF48, 8'h77);
      rd(16'hFF48, 8'h67);
      cpu.acc(1'b0, 1'b0, 16'hFF49, 8'h00);
      req(1'b1);
      complete_run();
   end
endmodule : program_loop_watchdog_bench
bind program_loop_watchdog loop_watchdog_props #(.CNT_W(CNT_W)) props (.*);
